// [include/pcr_defines.svh]
// Bit positions and codes for the synthesizer control words 4 to 6.
// Assumes words arrive whole, 32 bits, with the select field in bits 3:0.
`ifndef PCR_DEFINES_SVH
`define PCR_DEFINES_SVH

`define PCR_SEL_MAIN_INT   4'h0
`define PCR_SEL_REF_PUMP   4'h4
`define PCR_SEL_BLEED      4'h5
`define PCR_SEL_OUTPUT     4'h6
`define PCR_SEL_LSB        0
`define PCR_SEL_MSB        3

`define PCR_RP_DITHER2     30
`define PCR_RP_MUX_MSB     29
`define PCR_RP_MUX_LSB     27
`define PCR_RP_DOUBLER     26
`define PCR_RP_HALVING     25
`define PCR_RP_RDIV_MSB    24
`define PCR_RP_RDIV_LSB    15
`define PCR_RP_DBUF        14
`define PCR_RP_CUR_MSB     13
`define PCR_RP_CUR_LSB     10
`define PCR_RP_MUX_LEVEL   8
`define PCR_RP_POLARITY    7
`define PCR_RP_PWR_DOWN    6
`define PCR_RP_PUMP_TRI    5
`define PCR_RP_CNT_RST     4

`define PCR_BS_DELAY_MSB   27
`define PCR_BS_DELAY_LSB   26
`define PCR_BS_PULSED      25
`define PCR_BS_ABP_NARROW  23
`define PCR_BS_SLIP_RED    19

`define PCR_OC_DIFF_REF    30
`define PCR_OC_DIV_MSB     23
`define PCR_OC_DIV_LSB     21
`define PCR_OC_BLEED_MSB   20
`define PCR_OC_BLEED_LSB   13
`define PCR_OC_NEG_BLEED   12
`define PCR_OC_MUTE        11
`define PCR_OC_OUT_EN      6
`define PCR_OC_PWR_MSB     5
`define PCR_OC_PWR_LSB     4

`define PCR_WORD_RESET     32'h0000_0000
`define PCR_RDIV_ONE       10'h001

`endif

// [include/pcr_pkg.sv]
// Types shared by the control word decoder of the synthesizer.
// Assumes pcr_defines.svh supplies every bit position.
package pcr_pkg;

  // Reference path settings
  typedef struct packed {
    logic       dither2;
    logic [2:0] mux_select;
    logic       doubler;
    logic       reference_halving;
    logic [9:0] ref_divider;
    logic       mux_level;
    logic       differential_ref;
  } pcr_ref_s;

  // Phase detector and charge pump settings
  typedef struct packed {
    logic [3:0] pump_current;
    logic       polarity;
    logic       pump_tristate;
    logic       pulsed_bleed;
    logic [1:0] bleed_delay;
    logic       abp_narrow;
    logic       cycle_slip_reduction;
    logic       neg_bleed_en;
    logic [7:0] neg_bleed_level;
  } pcr_pump_s;

  // Output stage settings
  typedef struct packed {
    logic [2:0] out_divider;
    logic       mute_until_locked;
    logic       out_enable;
    logic [1:0] out_power;
    logic       out_supply_on;
  } pcr_out_s;

  // Power state of the synthesizer core
  typedef enum logic [1:0] {
    PCR_RUN,
    PCR_DOWN
  } pcr_power_e;

endpackage

// [core/pcr_control_regs.sv]
// Decoder and holding registers for synthesizer control words 4, 5 and 6.
// Assumes the serial shifter delivers a full word with a one-cycle load strobe,
// and that digital lock detect arrives as a level synchronous to clock.
`timescale 1ns/100ps
`include "pcr_defines.svh"

// Contract
// R01: Select 0100 loads reference/pump word, 0101 bleed word, 0110 output word.
// R02: Bit 30 of reference word enables second stage modulator dither.
// R03: Bits 29:27 of reference word pick the multiplexer output source.
// R04: Bit 26 clear passes reference directly; set doubles it, both edges active.
// R05: Bit 25 inserts divide-by-two toggle before phase detector.
// R06: Reference divider ratio is 1 to 1023; host never writes zero.
// R07: Output divider bits apply at main integer write when buffering enabled.
// R08: Bits 13:10 of reference word set charge pump current.
// R09: Bit 7 selects phase detector polarity.
// R10: Bit 6 set powers down, clear resumes; registers keep contents.
// R11: Power-down loads counters, tristates pump, resets lock, disables outputs.
// R12: Host writes integer 65535 prescaler 1 before power-down, restores before exit.
// R13: Bit 5 of reference word tristates the charge pump.
// R14: Bit 4 of reference word holds both counters in reset.
// R15: Bleed word bit 25 enables pulsed bleed with delay from bits 27:26.
// R16: Bit 23 clear uses bleed delay as antibacklash width; set uses 1.6 ns.
// R17: Bleed word bit 19 enables cycle slip reduction.
// R18: Output word bit 30 selects differential reference input.
// R19: Output word bits 23:21 select output divider ratio.
// R20: Bit 12 enables negative bleed; bits 20:13 set magnitude.
// R21: Mute bit keeps output supply off until digital lock.
// R22: Output word bits 5:4 select output power level.
// R23: Words are 32 bits with the select field in bits 3:0.
module pcr_control_regs
  import pcr_pkg::*;
#(
  parameter int WORD_W = 32
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Word from the serial shifter
  input  wire logic [WORD_W-1:0] load_word,
  input  wire logic              load_strobe,
  // Loop status
  input  wire logic              lock_detect,
  // Decoded settings
  output pcr_ref_s               ref_cfg,
  output pcr_pump_s              pump_cfg,
  output pcr_out_s               out_cfg,
  output logic                   power_down,
  output logic                   counters_hold,
  output logic                   counters_reset,
  output logic                   pump_tristate_eff,
  output logic                   lock_detect_clear,
  output logic                   out_buffers_off
);

  // Held words; contents survive power-down since nothing clears them but rst
  logic [WORD_W-1:0] ref_word;
  logic [WORD_W-1:0] bleed_word;
  logic [WORD_W-1:0] out_word;
  logic [2:0]        active_divider;
  pcr_power_e        power_state;

  // Select match for one word; shared by every register decode
  function automatic logic sel_is(input logic [WORD_W-1:0] w, input logic [3:0] code);
    logic [3:0] field;
    field = w[`PCR_SEL_MSB:`PCR_SEL_LSB]; // R23
    return field == code;
  endfunction

  // Select field decode
  wire logic       hit_ref       = load_strobe && sel_is(load_word, `PCR_SEL_REF_PUMP); // R01
  wire logic       hit_bleed     = load_strobe && sel_is(load_word, `PCR_SEL_BLEED); // R01
  wire logic       hit_out       = load_strobe && sel_is(load_word, `PCR_SEL_OUTPUT); // R01
  wire logic       hit_main      = load_strobe && sel_is(load_word, `PCR_SEL_MAIN_INT);

  // Buffering decision uses the currently held double-buffer enable
  wire logic       dbuf_on       = ref_word[`PCR_RP_DBUF];
  wire logic [2:0] new_div       = load_word[`PCR_OC_DIV_MSB:`PCR_OC_DIV_LSB];
  wire logic [2:0] held_div      = out_word[`PCR_OC_DIV_MSB:`PCR_OC_DIV_LSB];
  wire logic [2:0] next_divider  = (hit_out && !dbuf_on) ? new_div :
                                   hit_main ? held_div : active_divider; // R07 R19

  // Power-down follows the held bit; registers still load while down
  wire logic       pd_bit        = ref_word[`PCR_RP_PWR_DOWN]; // R10

  // Ratio zero is illegal; clamp so the divider never stalls
  wire logic [9:0] rdiv_raw      = ref_word[`PCR_RP_RDIV_MSB:`PCR_RP_RDIV_LSB];
  wire logic [9:0] rdiv_safe     = (rdiv_raw == 10'h000) ? `PCR_RDIV_ONE : rdiv_raw; // R06

  wire logic       mute_on       = out_word[`PCR_OC_MUTE];

  // Next output values
  pcr_ref_s  next_ref;
  pcr_pump_s next_pump;
  pcr_out_s  next_out;

  always_comb begin
    next_ref.dither2           = ref_word[`PCR_RP_DITHER2]; // R02
    next_ref.mux_select        = ref_word[`PCR_RP_MUX_MSB:`PCR_RP_MUX_LSB]; // R03
    next_ref.doubler           = ref_word[`PCR_RP_DOUBLER]; // R04
    next_ref.reference_halving = ref_word[`PCR_RP_HALVING]; // R05
    next_ref.ref_divider       = rdiv_safe; // R06
    next_ref.mux_level         = ref_word[`PCR_RP_MUX_LEVEL];
    next_ref.differential_ref  = out_word[`PCR_OC_DIFF_REF]; // R18
    next_pump.pump_current     = ref_word[`PCR_RP_CUR_MSB:`PCR_RP_CUR_LSB]; // R08
    next_pump.polarity         = ref_word[`PCR_RP_POLARITY]; // R09
    next_pump.pump_tristate    = ref_word[`PCR_RP_PUMP_TRI]; // R13
    next_pump.pulsed_bleed     = bleed_word[`PCR_BS_PULSED]; // R15
    next_pump.bleed_delay      = bleed_word[`PCR_BS_DELAY_MSB:`PCR_BS_DELAY_LSB]; // R15 R16
    next_pump.abp_narrow       = bleed_word[`PCR_BS_ABP_NARROW]; // R16
    next_pump.cycle_slip_reduction = bleed_word[`PCR_BS_SLIP_RED]; // R17
    next_pump.neg_bleed_en     = out_word[`PCR_OC_NEG_BLEED]; // R20
    next_pump.neg_bleed_level  = out_word[`PCR_OC_BLEED_MSB:`PCR_OC_BLEED_LSB]; // R20
    next_out.out_divider       = active_divider; // R19
    next_out.mute_until_locked = mute_on;
    next_out.out_enable        = out_word[`PCR_OC_OUT_EN];
    next_out.out_power         = out_word[`PCR_OC_PWR_MSB:`PCR_OC_PWR_LSB]; // R22
    next_out.out_supply_on     = !pd_bit && !(mute_on && !lock_detect); // R21 R11
  end

  // Word capture; loading stays live during power-down
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ref_word       <= `PCR_WORD_RESET;
      bleed_word     <= `PCR_WORD_RESET;
      out_word       <= `PCR_WORD_RESET;
      active_divider <= 3'h0;
    end else begin
      if (hit_ref) ref_word <= load_word; // R01 R11
      if (hit_bleed) bleed_word <= load_word; // R01
      if (hit_out) out_word <= load_word; // R01
      active_divider <= next_divider; // R07
    end
  end

  // Power state machine
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_state <= PCR_RUN;
    end else begin
      case (power_state)
        PCR_RUN:  if (pd_bit) power_state <= PCR_DOWN; // R10
        PCR_DOWN: if (!pd_bit) power_state <= PCR_RUN; // R10
        default:  power_state <= PCR_RUN;
      endcase
    end
  end

  // Registered outputs; power-down overrides apply one cycle after the bit lands
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ref_cfg           <= '0;
      pump_cfg          <= '0;
      out_cfg           <= '0;
      power_down        <= 1'b0;
      counters_hold     <= 1'b0;
      counters_reset    <= 1'b0;
      pump_tristate_eff <= 1'b0;
      lock_detect_clear <= 1'b0;
      out_buffers_off   <= 1'b0;
    end else begin
      ref_cfg           <= next_ref;
      pump_cfg          <= next_pump;
      out_cfg           <= next_out;
      power_down        <= pd_bit; // R10
      counters_hold     <= pd_bit; // R11
      counters_reset    <= ref_word[`PCR_RP_CNT_RST]; // R14
      pump_tristate_eff <= pd_bit || ref_word[`PCR_RP_PUMP_TRI]; // R11 R13
      lock_detect_clear <= pd_bit; // R11
      out_buffers_off   <= pd_bit; // R11
    end
  end

  // Word capture checks; a word followed at once by another word of the same
  // select is skipped where the check looks two edges ahead
  a_load_ref: assert property (@(posedge clock) disable iff (rst) // R01
    hit_ref |=> ref_word == $past(load_word))
    else $error("reference word not loaded");
  a_load_bleed: assert property (@(posedge clock) disable iff (rst) // R01
    hit_bleed |=> bleed_word == $past(load_word))
    else $error("bleed word not loaded");
  a_load_out: assert property (@(posedge clock) disable iff (rst) // R01
    hit_out |=> out_word == $past(load_word))
    else $error("output word not loaded");
  a_ref_ignore: assert property (@(posedge clock) disable iff (rst) // R01
    !hit_ref |=> ref_word == $past(ref_word))
    else $error("reference word changed without its select");
  a_dither_map: assert property (@(posedge clock) disable iff (rst) // R02
    hit_ref ##1 !hit_ref |=> ref_cfg.dither2 == $past(load_word[`PCR_RP_DITHER2], 2))
    else $error("dither bit wrong");
  a_mux_map: assert property (@(posedge clock) disable iff (rst) // R03
    hit_ref ##1 !hit_ref |=> ref_cfg.mux_select == $past(load_word[`PCR_RP_MUX_MSB:`PCR_RP_MUX_LSB], 2))
    else $error("mux select wrong");

  // Field mapping checks against the held words; the power level check uses the loaded output word
  a_doubler_map: assert property (@(posedge clock) disable iff (rst) // R04
    ref_cfg.doubler == $past(ref_word[`PCR_RP_DOUBLER]))
    else $error("doubler bit wrong");
  a_halving_map: assert property (@(posedge clock) disable iff (rst) // R05
    ref_cfg.reference_halving == $past(ref_word[`PCR_RP_HALVING]))
    else $error("halving bit wrong");
  a_rdiv_nonzero: assert property (@(posedge clock) disable iff (rst) // R06
    !$past(rst) |-> ref_cfg.ref_divider != 10'h000)
    else $error("divider zero");
  a_rdiv_clamp: assert property (@(posedge clock) disable iff (rst) // R06
    (rdiv_raw == 10'h000) |=> ref_cfg.ref_divider == `PCR_RDIV_ONE)
    else $error("zero ratio not clamped");
  a_current_map: assert property (@(posedge clock) disable iff (rst) // R08
    pump_cfg.pump_current == $past(ref_word[`PCR_RP_CUR_MSB:`PCR_RP_CUR_LSB]))
    else $error("pump current wrong");
  a_polarity_map: assert property (@(posedge clock) disable iff (rst) // R09
    pump_cfg.polarity == $past(ref_word[`PCR_RP_POLARITY]))
    else $error("polarity wrong");
  a_pulsed_map: assert property (@(posedge clock) disable iff (rst) // R15
    pump_cfg.pulsed_bleed == $past(bleed_word[`PCR_BS_PULSED]))
    else $error("pulsed bleed bit wrong");
  a_delay_map: assert property (@(posedge clock) disable iff (rst) // R15
    pump_cfg.bleed_delay == $past(bleed_word[`PCR_BS_DELAY_MSB:`PCR_BS_DELAY_LSB]))
    else $error("bleed delay wrong");
  a_abp_map: assert property (@(posedge clock) disable iff (rst) // R16
    pump_cfg.abp_narrow == $past(bleed_word[`PCR_BS_ABP_NARROW]))
    else $error("antibacklash select wrong");
  a_slip_map: assert property (@(posedge clock) disable iff (rst) // R17
    pump_cfg.cycle_slip_reduction == $past(bleed_word[`PCR_BS_SLIP_RED]))
    else $error("slip reduction bit wrong");
  a_diffref_map: assert property (@(posedge clock) disable iff (rst) // R18
    ref_cfg.differential_ref == $past(out_word[`PCR_OC_DIFF_REF]))
    else $error("reference mode wrong");
  a_negbleed_en: assert property (@(posedge clock) disable iff (rst) // R20
    pump_cfg.neg_bleed_en == $past(out_word[`PCR_OC_NEG_BLEED]))
    else $error("negative bleed enable wrong");
  a_negbleed_lvl: assert property (@(posedge clock) disable iff (rst) // R20
    pump_cfg.neg_bleed_level == $past(out_word[`PCR_OC_BLEED_MSB:`PCR_OC_BLEED_LSB]))
    else $error("negative bleed level wrong");
  a_power_map: assert property (@(posedge clock) disable iff (rst) // R22
    hit_out ##1 !hit_out |=> out_cfg.out_power == $past(load_word[`PCR_OC_PWR_MSB:`PCR_OC_PWR_LSB], 2))
    else $error("power level wrong");

  // Output divider buffering checks
  a_dbuf_wait: assert property (@(posedge clock) disable iff (rst) // R07
    (hit_out && dbuf_on && !hit_main) |=> active_divider == $past(active_divider))
    else $error("buffered divider changed early");
  a_dbuf_apply: assert property (@(posedge clock) disable iff (rst) // R07
    hit_main |=> active_divider == $past(held_div))
    else $error("divider not applied");
  a_direct_div: assert property (@(posedge clock) disable iff (rst) // R07
    (hit_out && !dbuf_on) |=> active_divider == $past(new_div))
    else $error("unbuffered divider not applied");
  a_div_out: assert property (@(posedge clock) disable iff (rst) // R19
    out_cfg.out_divider == $past(active_divider))
    else $error("output divider wrong");

  // Power-down, pump, counter and mute checks
  a_pd_output: assert property (@(posedge clock) disable iff (rst) // R10
    power_down == $past(pd_bit))
    else $error("power-down level wrong");
  a_pd_keeps: assert property (@(posedge clock) disable iff (rst) // R10
    (pd_bit && !hit_bleed) |=> bleed_word == $past(bleed_word))
    else $error("content lost");
  a_pd_effects: assert property (@(posedge clock) disable iff (rst) // R11
    pd_bit |=> pump_tristate_eff && counters_hold && out_buffers_off && !out_cfg.out_supply_on)
    else $error("power-down effects missing");
  a_pd_lock_clr: assert property (@(posedge clock) disable iff (rst) // R11
    pd_bit |=> lock_detect_clear)
    else $error("lock detect not cleared");
  a_pump_normal: assert property (@(posedge clock) disable iff (rst) // R13
    (!pd_bit && !ref_word[`PCR_RP_PUMP_TRI]) |=> !pump_tristate_eff)
    else $error("pump tristated without cause");
  a_pump_tri: assert property (@(posedge clock) disable iff (rst) // R13
    ref_word[`PCR_RP_PUMP_TRI] |=> pump_tristate_eff && pump_cfg.pump_tristate)
    else $error("pump tristate missing");
  a_cnt_reset: assert property (@(posedge clock) disable iff (rst) // R14
    ref_word[`PCR_RP_CNT_RST] |=> counters_reset)
    else $error("counter reset missing");
  a_cnt_release: assert property (@(posedge clock) disable iff (rst) // R14
    !ref_word[`PCR_RP_CNT_RST] |=> !counters_reset)
    else $error("counter reset stuck");
  a_mute_lock: assert property (@(posedge clock) disable iff (rst) // R21
    (mute_on && !lock_detect) |=> !out_cfg.out_supply_on)
    else $error("mute ignored");
  a_supply_lock: assert property (@(posedge clock) disable iff (rst) // R21
    (!pd_bit && lock_detect) |=> out_cfg.out_supply_on)
    else $error("supply off while locked");

  c_pd_entry: cover property (@(posedge clock) disable iff (rst) power_state == PCR_DOWN);
  c_dbuf_path: cover property (@(posedge clock) disable iff (rst) hit_out && dbuf_on ##[1:20] hit_main);
  c_direct_div: cover property (@(posedge clock) disable iff (rst) hit_out && !dbuf_on);
  c_mute_held: cover property (@(posedge clock) disable iff (rst) mute_on && !lock_detect);
  c_back_to_back: cover property (@(posedge clock) disable iff (rst) hit_ref ##1 hit_bleed);

endmodule

// [sim/pcr_host_model.sv]
// Host side model that hands whole control words to the register bank.
// Assumes the caller is at a rising clock edge when it calls send.
`timescale 1ns/100ps
module pcr_host_model (
  // Clock
  input  wire logic        clock,
  // Word toward the register bank
  output logic      [31:0] load_word,
  output logic             load_strobe
);
  initial begin
    load_word   = 32'h0000_0000;
    load_strobe = 1'b0;
  end

  // Gap 0 keeps the strobe up so the next word follows back to back
  task automatic send(input logic [31:0] w, input int gap);
    load_word   <= w;
    load_strobe <= 1'b1;
    @(posedge clock);
    if (gap > 0) begin
      load_strobe <= 1'b0;
      load_word   <= ~w; // Idle bus never repeats the last word
      repeat (gap) @(posedge clock);
    end
  endtask
endmodule

// [sim/tb.sv]
// Self-checking bench for the control word register bank.
// Assumes outputs follow a taken word two edges later.
`timescale 1ns/100ps
module tb;
  import pcr_pkg::*;
  typedef struct packed {pcr_ref_s r; pcr_pump_s p; pcr_out_s o; logic [5:0] f;} pcr_exp_s;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        lock_detect = 1'b1;
  logic [31:0] load_word;
  logic        load_strobe;
  pcr_ref_s    ref_cfg;
  pcr_pump_s   pump_cfg;
  pcr_out_s    out_cfg;
  logic        power_down, counters_hold, counters_reset, pump_tristate_eff, lock_detect_clear, out_buffers_off;
  logic [31:0] w4 = 32'h0, w5 = 32'h0, w6 = 32'h0, seed = 32'h41E7;
  logic [2:0]  div_act = 3'h0;
  logic        d1 = 1'b0, d2 = 1'b0;
  pcr_exp_s    expq[$];
  int          fail_count = 0, cmp_count = 0, cycles = 0;

  always #4 clock = ~clock;

  pcr_host_model host_inst (.clock(clock), .load_word(load_word), .load_strobe(load_strobe));
  pcr_control_regs pcr_control_regs_inst (.clock(clock), .rst(rst), .load_word(load_word),
    .load_strobe(load_strobe), .lock_detect(lock_detect), .ref_cfg(ref_cfg), .pump_cfg(pump_cfg),
    .out_cfg(out_cfg), .power_down(power_down), .counters_hold(counters_hold),
    .counters_reset(counters_reset), .pump_tristate_eff(pump_tristate_eff),
    .lock_detect_clear(lock_detect_clear), .out_buffers_off(out_buffers_off));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Expected outputs from the words held so far
  function automatic pcr_exp_s predict();
    pcr_exp_s e;
    e.r = {w4[30], w4[29:27], w4[26], w4[25], (w4[24:15] == 10'h000) ? 10'h001 : w4[24:15], w4[8], w6[30]};
    e.p = {w4[13:10], w4[7], w4[5], w5[25], w5[27:26], w5[23], w5[19], w6[12], w6[20:13]};
    e.o = {div_act, w6[11], w6[6], w6[5:4], ~w4[6] & ~(w6[11] & ~lock_detect)};
    e.f = {w4[6], w4[6], w4[4], w4[6] | w4[5], w4[6], w4[6]};
    return e;
  endfunction

  task automatic check(input pcr_exp_s seen, input pcr_exp_s exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t outputs %h expected %h", $time, seen, exp);
    end
  endtask

  // Update the bench copy, note the expectation, then send the word
  task automatic put(input logic [3:0] sel, input logic [31:0] data, input int gap);
    logic [31:0] w;
    w = {data[31:4], sel};
    if (w[24:15] == 10'h000) w[15] = 1'b1;
    if (sel == 4'h4) w4 = w;
    if (sel == 4'h5) w5 = w;
    if (sel == 4'h6) begin
      w6 = w;
      if (!w4[14]) div_act = w[23:21];
    end
    if (sel == 4'h0) div_act = w6[23:21];
    expq.push_back(predict());
    host_inst.send(w, gap);
  endtask

  task automatic conclude();
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Watcher: compare two edges after each taken word
  always @(posedge clock) begin
    cycles++;
    if (cycles > 3000) begin
      fail_count++;
      conclude();
    end
    if (d2) check({ref_cfg, pump_cfg, out_cfg, power_down, counters_hold, counters_reset,
                   pump_tristate_eff, lock_detect_clear, out_buffers_off}, expq.pop_front());
    d2 = d1;
    d1 = load_strobe;
  end

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // Every select code, random payloads, some back to back
    for (int i = 0; i < 96; i++) begin
      seed = lfsr(seed);
      put(i[3:0], seed, (i % 3 == 0) ? 0 : i % 4);
    end
    // Buffered divider waits for the main integer word
    put(4'h4, 32'h0000_4000, 1);
    put(4'h6, 32'h00A0_0000, 2);
    put(4'h0, 32'h000F_FFF0, 1);
    // Power-down entry and exit, muted output waiting for lock
    put(4'h0, 32'h000F_FFF0, 1);
    put(4'h4, 32'h0000_0040, 1);
    lock_detect <= 1'b0;
    repeat (3) @(posedge clock);
    put(4'h6, 32'h0000_0870, 1);
    put(4'h0, 32'h0000_1230, 1);
    put(4'h4, 32'h0000_0000, 1);
    lock_detect <= 1'b1;
    repeat (3) @(posedge clock);
    put(4'h5, 32'h0E88_0000, 4);
    conclude();
  end
endmodule
